// File: shared/fsn_params.svh
// Register map, field positions, reset values and timing figures of the fault and programming block.
`ifndef FSN_PARAMS_SVH
`define FSN_PARAMS_SVH

// System clock rate.
`define FSN_CLK_MHZ 50

// Register addresses.
`define FSN_ADDR_FAULT 8'h54
`define FSN_ADDR_PROG 8'h60
`define FSN_ADDR_UNLOCK 8'h61
`define FSN_CUST_LAST 8'h0b
`define FSN_CUST_NUM 12

// Program control fields and values.
`define FSN_PROG_CODE 5'h12
`define FSN_PROG_CODE_MSB 7
`define FSN_PROG_CODE_LSB 3
`define FSN_PROG_DONE_BIT 1
`define FSN_PROG_RSV0 1'b1
`define FSN_UNLOCK_KEY 8'h61
`define FSN_UNLOCK_RST 8'h00
`define FSN_NVM_BLANK 8'h00
`define FSN_RD_NONE 8'h00

// Fault summary bit positions.
`define FSN_FLT_SHORT 2
`define FSN_FLT_OCP 1
`define FSN_FLT_OT 0

// Protection and program timing in printed units and derived cycle counts.
`define FSN_OC_DLY_MS 1
`define FSN_OC_DLY_CYC (`FSN_OC_DLY_MS * 1000 * `FSN_CLK_MHZ)
`define FSN_OT_DLY_US 160
`define FSN_OT_DLY_CYC (`FSN_OT_DLY_US * `FSN_CLK_MHZ)
`define FSN_HICCUP_MS 10
`define FSN_HICCUP_CYC (`FSN_HICCUP_MS * 1000 * `FSN_CLK_MHZ)
`define FSN_START_MS 2
`define FSN_START_CYC (`FSN_START_MS * 1000 * `FSN_CLK_MHZ)
`define FSN_PROG_MS 10
`define FSN_PROG_CYC (`FSN_PROG_MS * 1000 * `FSN_CLK_MHZ)

`endif

// File: shared/fsn_pkg.sv
// Types shared by the fault and programming block.
`default_nettype none
package fsn_pkg;

    // Protection state machine states.
    typedef enum logic [1:0] {
        FSN_ST_START = 2'b00,
        FSN_ST_RUN = 2'b01,
        FSN_ST_HICCUP = 2'b10,
        FSN_ST_OT_OFF = 2'b11
    } fsn_state_e;

    // One register byte.
    typedef logic [7:0] fsn_byte_t;

endpackage : fsn_pkg
`default_nettype wire

// File: design/fsn_nvm_store.sv
// Nonvolatile store for the customer registers with a timed program cycle.
`timescale 1ns/1ps
`default_nettype none
`include "fsn_params.svh"

module fsn_nvm_store
    import fsn_pkg::*;
#(
    parameter int N = `FSN_CUST_NUM,
    parameter int PROG_CYC = `FSN_PROG_CYC,
    parameter int CNT_W = 24
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [N*8-1:0] wr_data_i,
    output logic [N*8-1:0] rd_data_o,
    output logic busy_o,
    output logic done_o
);

    // Blank contents for a part that has never been programmed; reset never touches the store.
    fsn_byte_t mem_q [N] = '{default: `FSN_NVM_BLANK};
    fsn_byte_t snap_q [N];
    logic [CNT_W-1:0] cnt_q;
    logic busy_q;
    logic done_q;
    logic last_w;

    // The cycle ends when the counter reaches its final value.
    assign last_w = busy_q && (cnt_q == CNT_W'(PROG_CYC - 1));
    assign busy_o = busy_q;
    assign done_o = done_q;

    // Cycle timer; the store itself is not touched by reset so it survives power cycles.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            done_q <= last_w;
            if (start_i && !busy_q) begin
                busy_q <= 1'b1;
                cnt_q <= '0;
            end else if (last_w) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                cnt_q <= cnt_q + CNT_W'(1);
            end
        end
    end

    // Snapshot at start, commit at the end, one byte per entry.
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_byte
            always_ff @(posedge clk_sys_i) begin
                if (start_i && !busy_q) begin
                    snap_q[i] <= wr_data_i[i*8 +: 8];
                end
                if (last_w) begin
                    mem_q[i] <= snap_q[i];
                end
            end
            assign rd_data_o[i*8 +: 8] = mem_q[i];
        end
    endgenerate

    // A finished cycle holds the snapshot taken at its start; only the first and last entries are compared.
    chk_nvm_commit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        done_q |-> (mem_q[0] == snap_q[0]) && (mem_q[N-1] == snap_q[N-1]))
        else $error("nvm contents differ from programmed snapshot");

endmodule : fsn_nvm_store
`default_nettype wire

// File: design/fsn_top.sv
// Fault flags, nonvolatile programming control and protection state machine of the converter.
// Function
// - Three read-only fault flags, reset to zero.
// - Code 10010 starts copying registers to memory.
// - Programmed values load at next start-up.
// - Done clears on command, sets at completion.
// - Undervoltage forces immediate power-on reset.
// - Overcurrent for 1ms shuts down, hiccups.
// - Hiccup retries start-up while overcurrent persists.
// - Short circuit shuts down at once, hiccups.
// - Cleared fault returns to normal operation.
// - Overtemperature over 160us turns output off.
// - Output returns once temperature falls back.
// - Persisting overtemperature keeps output off.
`timescale 1ns/1ps
`default_nettype none
`include "fsn_params.svh"

module fsn_top
    import fsn_pkg::*;
#(
    parameter int OC_CYC = `FSN_OC_DLY_CYC,
    parameter int OT_CYC = `FSN_OT_DLY_CYC,
    parameter int HICCUP_CYC = `FSN_HICCUP_CYC,
    parameter int START_CYC = `FSN_START_CYC,
    parameter int PROG_CYC = `FSN_PROG_CYC,
    parameter int TMR_W = 24
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic uvlo_i,
    input wire logic oc_i,
    input wire logic sc_i,
    input wire logic ot_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic output_enable_o,
    output logic power_good_output_o,
    output logic por_o
);

    fsn_state_e st_q;
    fsn_state_e st_d;
    fsn_byte_t cust_q [`FSN_CUST_NUM];
    logic [`FSN_CUST_NUM*8-1:0] cust_flat;
    logic [`FSN_CUST_NUM*8-1:0] nvm_rd;
    logic [TMR_W-1:0] tmr_q;
    logic [TMR_W-1:0] tmr_d;
    logic [TMR_W-1:0] oc_cnt_q;
    logic [TMR_W-1:0] ot_cnt_q;
    logic [4:0] code_q;
    logic [2:0] flt_q;
    logic [2:0] flt_set;
    logic [2:0] flt_cond;
    fsn_byte_t unlock_q;
    fsn_byte_t rd_mux;
    fsn_byte_t prog_rd;
    logic done_q;
    logic nvm_busy;
    logic nvm_done;
    logic por;
    logic wr_prog;
    logic wr_unlock;
    logic unlocked;
    logic prog_go;
    logic out_on;
    logic oc_trip;
    logic ot_trip;
    logic sc_trip;
    logic start_end;
    logic hic_end;

    // Undervoltage acts as a power-on reset with no filtering.
    assign por = rst_i | uvlo_i;

    // Register write decode and program command qualification.
    assign wr_prog = reg_wr_i && (reg_addr_i == `FSN_ADDR_PROG);
    assign wr_unlock = reg_wr_i && (reg_addr_i == `FSN_ADDR_UNLOCK);
    assign unlocked = (unlock_q == `FSN_UNLOCK_KEY);
    assign prog_go = wr_prog && unlocked && !nvm_busy &&
        (reg_wdata_i[`FSN_PROG_CODE_MSB:`FSN_PROG_CODE_LSB] == `FSN_PROG_CODE);

    // Read data: reserved bits read zero, bit 0 of program control reads one.
    assign prog_rd = {code_q, 1'b0, done_q, `FSN_PROG_RSV0};
    assign rd_mux = (reg_addr_i <= `FSN_CUST_LAST) ? cust_q[reg_addr_i[3:0]] :
                    (reg_addr_i == `FSN_ADDR_PROG) ? prog_rd :
                    (reg_addr_i == `FSN_ADDR_UNLOCK) ? unlock_q :
                    (reg_addr_i == `FSN_ADDR_FAULT) ? {5'h00, flt_q} : `FSN_RD_NONE;

    // Customer registers reload from the nonvolatile store at every power-on reset.
    genvar i;
    generate
        for (i = 0; i < `FSN_CUST_NUM; i++) begin : g_cust
            always_ff @(posedge clk_sys_i) begin
                if (por) begin
                    cust_q[i] <= nvm_rd[i*8 +: 8];
                end else if (reg_wr_i && (reg_addr_i == 8'(i))) begin
                    cust_q[i] <= reg_wdata_i;
                end
            end
            assign cust_flat[i*8 +: 8] = cust_q[i];
        end
    endgenerate

    // Nonvolatile store that copies customer registers on command.
    fsn_nvm_store #(
        .N(`FSN_CUST_NUM),
        .PROG_CYC(PROG_CYC),
        .CNT_W(TMR_W)
    ) u_nvm (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .start_i(prog_go),
        .wr_data_i(cust_flat),
        .rd_data_o(nvm_rd),
        .busy_o(nvm_busy),
        .done_o(nvm_done)
    );

    // Program control, unlock key and read data registers.
    always_ff @(posedge clk_sys_i) begin
        if (por) begin
            code_q <= 5'h00;
            unlock_q <= `FSN_UNLOCK_RST;
            done_q <= 1'b0;
            reg_rdata_o <= `FSN_RD_NONE;
        end else begin
            if (wr_prog) begin
                code_q <= reg_wdata_i[`FSN_PROG_CODE_MSB:`FSN_PROG_CODE_LSB];
            end
            if (wr_unlock) begin
                unlock_q <= reg_wdata_i;
            end
            if (prog_go) begin
                done_q <= 1'b0;
            end else if (nvm_done) begin
                done_q <= 1'b1;
            end
            if (reg_rd_i) begin
                reg_rdata_o <= rd_mux;
            end
        end
    end

    // Trip detection: short acts at once, overload and heat only after their delays.
    assign out_on = (st_q == FSN_ST_START) || (st_q == FSN_ST_RUN);
    assign sc_trip = out_on && sc_i;
    assign oc_trip = (st_q == FSN_ST_RUN) && oc_i && (oc_cnt_q == TMR_W'(OC_CYC - 1));
    assign ot_trip = out_on && ot_i && (ot_cnt_q == TMR_W'(OT_CYC - 1));
    assign start_end = (st_q == FSN_ST_START) && (tmr_q == TMR_W'(START_CYC - 1));
    assign hic_end = (st_q == FSN_ST_HICCUP) && (tmr_q == TMR_W'(HICCUP_CYC - 1));

    // Persistence counters for overload and overtemperature.
    always_ff @(posedge clk_sys_i) begin
        if (por || (st_q != FSN_ST_RUN) || !oc_i) begin
            oc_cnt_q <= '0;
        end else if (!oc_trip) begin
            oc_cnt_q <= oc_cnt_q + TMR_W'(1);
        end
        if (por || !out_on || !ot_i) begin
            ot_cnt_q <= '0;
        end else if (!ot_trip) begin
            ot_cnt_q <= ot_cnt_q + TMR_W'(1);
        end
    end

    // Next state of the protection sequencer.
    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q + TMR_W'(1);
        case (st_q)
            FSN_ST_START: begin
                if (sc_trip) begin
                    st_d = FSN_ST_HICCUP;
                    tmr_d = '0;
                end else if (ot_trip) begin
                    st_d = FSN_ST_OT_OFF;
                end else if (start_end) begin
                    st_d = oc_i ? FSN_ST_HICCUP : FSN_ST_RUN;
                    tmr_d = '0;
                end
            end
            FSN_ST_RUN: begin
                tmr_d = '0;
                if (sc_trip || oc_trip) begin
                    st_d = FSN_ST_HICCUP;
                end else if (ot_trip) begin
                    st_d = FSN_ST_OT_OFF;
                end
            end
            FSN_ST_HICCUP: begin
                if (hic_end) begin
                    st_d = FSN_ST_START;
                    tmr_d = '0;
                end
            end
            FSN_ST_OT_OFF: begin
                tmr_d = '0;
                if (!ot_i) begin
                    st_d = FSN_ST_START;
                end
            end
            default: begin
                st_d = FSN_ST_START;
                tmr_d = '0;
            end
        endcase
    end

    // Fault flags latch on trip and clear only once running clean again.
    assign flt_set = {sc_trip, oc_trip || (start_end && oc_i && !sc_trip && !ot_trip), ot_trip};
    assign flt_cond = {sc_i, oc_i, ot_i};

    // State, timer, flags and converter outputs.
    always_ff @(posedge clk_sys_i) begin
        por_o <= por;
        if (por) begin
            st_q <= FSN_ST_START;
            tmr_q <= '0;
            flt_q <= 3'h0;
            output_enable_o <= 1'b0;
            power_good_output_o <= 1'b0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            flt_q <= flt_set | (flt_q & (flt_cond | {3{st_q != FSN_ST_RUN}}));
            output_enable_o <= (st_d == FSN_ST_START) || (st_d == FSN_ST_RUN);
            power_good_output_o <= (st_d == FSN_ST_RUN);
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (por);

    // Program start sequence: accepted write, then busy with done low.
    sequence s_prog_cmd;
        prog_go;
    endsequence
    sequence s_prog_busy;
        nvm_busy && !done_q;
    endsequence

    chk_flag_reset: assert property (disable iff (1'b0) por |=> (flt_q == 3'h0) && !output_enable_o)
        else $error("fault flags or output not cleared by reset");
    chk_prog_start: assert property (s_prog_cmd |=> s_prog_busy)
        else $error("program command did not start a cycle");
    chk_done_busy: assert property (nvm_busy |-> !done_q)
        else $error("done flag high during program cycle");
    chk_locked_ignore: assert property (wr_prog && !unlocked && !nvm_busy |=> !nvm_busy && $stable(done_q))
        else $error("program command accepted while locked");
    chk_short_at_once: assert property (sc_trip |=> !output_enable_o && !power_good_output_o && flt_q[2])
        else $error("short did not shut output down at once");
    chk_oc_delay: assert property ((st_q == FSN_ST_RUN) && !sc_i && !ot_i && !oc_trip |=> st_q == FSN_ST_RUN)
        else $error("overload tripped before its delay");
    chk_oc_hiccup: assert property (oc_trip && !sc_i |=> (st_q == FSN_ST_HICCUP) && !power_good_output_o)
        else $error("overload did not enter hiccup");
    chk_retry_fail: assert property (start_end && oc_i |=> st_q == FSN_ST_HICCUP)
        else $error("retry with overload did not return to hiccup");
    chk_return_run: assert property (start_end && !oc_i && !sc_i && !ot_trip |=> power_good_output_o)
        else $error("clean start-up did not return to normal operation");
    chk_ot_trip: assert property (ot_trip && !sc_i |=> (st_q == FSN_ST_OT_OFF) && !output_enable_o)
        else $error("overtemperature did not turn output off");
    chk_ot_hold: assert property ((st_q == FSN_ST_OT_OFF) && ot_i |=> !output_enable_o)
        else $error("output on while overtemperature persists");
    chk_ot_recover: assert property ((st_q == FSN_ST_OT_OFF) && !ot_i |=> output_enable_o)
        else $error("output not restored after cooling");

endmodule : fsn_top
`default_nettype wire

// File: test/fsn_host_model.sv
// Host model that reaches the registers through the one-cycle strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "fsn_params.svh"

module fsn_host_model (
    input wire logic clk_sys_i,
    input wire logic [7:0] reg_rdata_i,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    // Idle bus at time zero.
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'hff;
        reg_wdata_o = 8'h00;
    end

    // One strobe held over one rising edge; address and data are scrambled once released.
    task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        reg_wr_o = is_wr;
        reg_rd_o = ~is_wr;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(negedge clk_sys_i);
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask : xfer

    // Single byte write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    // Read data is registered at the taking edge, so it is sampled one edge later.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        xfer(1'b0, a, 8'h00);
        @(negedge clk_sys_i);
        d = reg_rdata_i;
    endtask : rd

    // Unlock first, then the start byte with the read-only low bits written as zero.
    task automatic prog();
        wr(`FSN_ADDR_UNLOCK, `FSN_UNLOCK_KEY);
        wr(`FSN_ADDR_PROG, {`FSN_PROG_CODE, 3'b000});
    endtask : prog
endmodule : fsn_host_model
`default_nettype wire

// File: test/fsn_top_tb.sv
// Self-checking testbench for the fault flags, programming control and protection logic.
`timescale 1ns/1ps
`default_nettype none
`include "fsn_params.svh"

module fsn_top_tb;
    import fsn_pkg::*;
    localparam int OC = 8;
    localparam int OT = 6;
    localparam int HIC = 10;
    localparam int ST = 5;
    localparam int PG = 4;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic uvlo_i = 1'b0;
    logic oc_i = 1'b0;
    logic sc_i = 1'b0;
    logic ot_i = 1'b0;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic oe;
    logic pg;
    logic por;
    int num_errors = 0;
    int n_tests = 0;
    int n;
    fsn_byte_t d;

    // Free-running 50 MHz clock.
    always #10 clk_sys_i = ~clk_sys_i;

    fsn_top #(.OC_CYC(OC), .OT_CYC(OT), .HICCUP_CYC(HIC), .START_CYC(ST), .PROG_CYC(PG)) i_fsn_top (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .uvlo_i(uvlo_i), .oc_i(oc_i), .sc_i(sc_i), .ot_i(ot_i),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .output_enable_o(oe), .power_good_output_o(pg), .por_o(por));

    fsn_host_model i_fsn_host_model (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_wr_o(reg_wr),
        .reg_rd_o(reg_rd), .reg_addr_o(addr), .reg_wdata_o(wdata));

    // Byte and bit comparisons with counting.
    task automatic chk8(input string nm, input fsn_byte_t exp, input fsn_byte_t got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk1

    task automatic rdchk(input fsn_byte_t a, input fsn_byte_t exp, input string nm);
        i_fsn_host_model.rd(a, d);
        chk8(nm, exp, d);
    endtask : rdchk

    task automatic cyc(input int k);
        repeat (k) @(negedge clk_sys_i);
    endtask : cyc

    // Bounded wait for the output enable to reach a level; running out counts as a mismatch.
    task automatic wait_oe(input logic v, input int maxc, output int k);
        k = 0;
        while (oe !== v && k < maxc) begin
            @(negedge clk_sys_i);
            k++;
        end
        chk1("output enable wait", v, oe);
    endtask : wait_oe

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    // Watchdog well beyond the few hundred cycles the sequence needs.
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        num_errors++;
        $display("[ERR] watchdog expected finish seen timeout");
        summarize();
    end

    // Main sequence.
    initial begin
        cyc(3);
        rst_i = 1'b0;
        rdchk(`FSN_ADDR_FAULT, 8'h00, "fault summary reset");
        rdchk(`FSN_ADDR_PROG, 8'h01, "program control reset");
        rdchk(`FSN_ADDR_UNLOCK, 8'h00, "unlock reset");
        rdchk(8'h70, 8'h00, "unmapped read");
        chk1("power good after start", 1'b1, pg);
        i_fsn_host_model.wr(`FSN_ADDR_PROG, {`FSN_PROG_CODE, 3'b000});
        cyc(PG + 2);
        rdchk(`FSN_ADDR_PROG, {`FSN_PROG_CODE, 3'b001}, "program without key");
        for (int i = 0; i < `FSN_CUST_NUM; i++) i_fsn_host_model.wr(i[7:0], 8'ha0 + i[7:0]);
        i_fsn_host_model.prog();
        rdchk(`FSN_ADDR_PROG, {`FSN_PROG_CODE, 3'b001}, "done low while busy");
        cyc(PG + 2);
        rdchk(`FSN_ADDR_PROG, {`FSN_PROG_CODE, 3'b011}, "done after cycle");
        // A wrong code while unlocked is stored but starts nothing; a second command clears done again.
        i_fsn_host_model.wr(`FSN_ADDR_PROG, 8'h88);
        rdchk(`FSN_ADDR_PROG, 8'h8b, "wrong code ignored");
        i_fsn_host_model.prog();
        rdchk(`FSN_ADDR_PROG, {`FSN_PROG_CODE, 3'b001}, "done cleared by command");
        cyc(PG + 2);
        rdchk(`FSN_ADDR_PROG, {`FSN_PROG_CODE, 3'b011}, "done after second cycle");
        for (int i = 0; i < `FSN_CUST_NUM; i++) i_fsn_host_model.wr(i[7:0], 8'h5a);
        uvlo_i = 1'b1;
        cyc(2);
        chk1("por on undervoltage", 1'b1, por);
        chk1("output off on undervoltage", 1'b0, oe);
        uvlo_i = 1'b0;
        cyc(2);
        chk1("por released", 1'b0, por);
        for (int i = 0; i < `FSN_CUST_NUM; i++) rdchk(i[7:0], 8'ha0 + i[7:0], "customer reload");
        // Short circuit with retries while the short persists.
        sc_i = 1'b1;
        wait_oe(1'b0, 2, n);
        chk1("power good on short", 1'b0, pg);
        rdchk(`FSN_ADDR_FAULT, 8'h04, "short flag");
        wait_oe(1'b1, HIC + 4, n);
        wait_oe(1'b0, 3, n);
        sc_i = 1'b0;
        wait_oe(1'b1, HIC + 4, n);
        cyc(ST + 2);
        chk1("power good after short", 1'b1, pg);
        rdchk(`FSN_ADDR_FAULT, 8'h00, "short flag cleared");
        // Overcurrent with the detection delay and a failed retry.
        oc_i = 1'b1;
        cyc(OC - 2);
        chk1("output before delay", 1'b1, oe);
        wait_oe(1'b0, 4, n);
        chk1("power good on overcurrent", 1'b0, pg);
        rdchk(`FSN_ADDR_FAULT, 8'h02, "overcurrent flag");
        wait_oe(1'b1, HIC + 4, n);
        wait_oe(1'b0, ST + 3, n);
        oc_i = 1'b0;
        wait_oe(1'b1, HIC + 4, n);
        cyc(ST + 2);
        chk1("power good after overcurrent", 1'b1, pg);
        // Overtemperature: short pulse ignored, long one trips, output back once cooled.
        ot_i = 1'b1;
        cyc(OT - 2);
        ot_i = 1'b0;
        cyc(2);
        chk1("output after short heat", 1'b1, oe);
        ot_i = 1'b1;
        cyc(OT - 2);
        chk1("output before heat delay", 1'b1, oe);
        wait_oe(1'b0, 4, n);
        chk1("power good on heat", 1'b0, pg);
        rdchk(`FSN_ADDR_FAULT, 8'h01, "thermal flag");
        cyc(HIC + ST + 4);
        chk1("output while hot", 1'b0, oe);
        rdchk(`FSN_ADDR_FAULT, 8'h01, "thermal flag held");
        ot_i = 1'b0;
        wait_oe(1'b1, 4, n);
        cyc(ST + 2);
        chk1("power good after heat", 1'b1, pg);
        rdchk(`FSN_ADDR_FAULT, 8'h00, "flags clear");
        summarize();
    end
endmodule : fsn_top_tb
`default_nettype wire
